// >>> logic/tdmmx_defs.svh
/*
 constants of the 2048 kbit/s slot multiplexer: register offsets, field positions,
 reset values and timing figures.
 assumes inclusion by bare name from the package and the design files.
*/
`ifndef TDMMX_DEFS_SVH
`define TDMMX_DEFS_SVH

// timing
`define TDMMX_CLK_HZ 200000000
`define TDMMX_BIT_HZ 2048000
`define TDMMX_BIT_GAP_MIN 8'h61
`define TDMMX_BIT_GAP_MAX 8'h62

// frame layout
`define TDMMX_SLOT_ALIGN 5'h00
`define TDMMX_SLOT_SIG 5'h10
`define TDMMX_SLOTS 32
`define TDMMX_VOICE_INV 8'h55
`define TDMMX_NUM_VOICE 5'h1E
`define TDMMX_NO_GROUP 3'h7

// register offsets
`define TDMMX_OFS_CTRL 6'h00
`define TDMMX_OFS_MAP 6'h01
`define TDMMX_OFS_VOICE 6'h02
`define TDMMX_OFS_STATUS 6'h03

// control fields and reset values
`define TDMMX_CTRL_TSRC 1:0
`define TDMMX_CTRL_VOICE 2
`define TDMMX_CTRL_SOUND 13:8
`define TDMMX_MAP_RST 32'h1E0E1606

// voice sample fields
`define TDMMX_VOICE_MAG 11:0
`define TDMMX_VOICE_NEG 12
`define TDMMX_VOICE_CH 20:16

// bus answers
`define TDMMX_RESP_OKAY 2'h0
`define TDMMX_RESP_DECERR 2'h3

`endif

// >>> logic/tdmmx_pkg.sv
/*
 types of the 2048 kbit/s slot multiplexer: port vectors, modes, state record
 and the companding function.
 assumes tdmmx_defs.svh is on the include path.
*/
`include "tdmmx_defs.svh"

package tdmmx_pkg;

	typedef logic [3:0] tdmmx_acc_t;
	typedef logic [5:0] tdmmx_snd_t;

	typedef enum logic [1:0] {
		TSRC_INTERNAL = 2'h0,
		TSRC_EXTERNAL = 2'h1,
		TSRC_RECEIVED = 2'h2
	} tdmmx_tsrc_t;

	typedef enum logic [3:0] {
		SRC_PASS = 4'h1,
		SRC_SOUND = 4'h2,
		SRC_ACCESS = 4'h4,
		SRC_VOICE = 4'h8
	} tdmmx_src_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [5:0] aw_word;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] ctrl;
		logic [31:0] map;
		logic mem_we;
		logic [4:0] mem_waddr;
		logic [7:0] mem_wdata;
		logic [31:0] nco;
		logic strobe;
		logic [2:0] ref_s;
		logic [2:0] rcv_s;
		logic [1:0] ifs_s;
		logic [1:0] efs_s;
		logic [1:0] ins_s;
		logic [1:0] ext_s;
		tdmmx_acc_t a64_s1;
		tdmmx_acc_t a64_s2;
		tdmmx_snd_t snd_s1;
		tdmmx_snd_t snd_s2;
		logic [7:0] ipos;
		logic [7:0] epos;
		logic ins_out;
		logic ext_out;
		tdmmx_acc_t e64_out;
		tdmmx_snd_t esnd_out;
		tdmmx_acc_t acc_act;
		tdmmx_snd_t snd_act;
		logic timing_out;
		logic sound_timing;
		logic [7:0] gap;
		logic [15:0] frames;
	} tdmmx_state_t;

	// linear sign-magnitude sample to eight-bit segment code, before inversion
	function automatic logic [7:0] tdmmx_alaw(input logic neg, input logic [11:0] mag);
		logic [2:0] seg;
		logic [3:0] mant;
		seg = 3'h0;
		mant = mag[4:1];
		for (int k = 1; k < 8; k++) begin
			if (mag[k + 4]) begin
				seg = 3'(k);
				mant = mag[k + 3 -: 4];
			end
		end
		return {~neg, seg, mant};
	endfunction

	// slot to sound-programme group A..F, or none
	function automatic logic [2:0] tdmmx_group(input logic [4:0] slot);
		logic [4:0] rel;
		rel = 5'h00;
		if (slot >= 5'h01 && slot <= 5'h0F) begin
			rel = slot - 5'h01;
			return 3'(rel / 5'h05);
		end
		if (slot >= 5'h11) begin
			rel = slot - 5'h11;
			return 3'(rel / 5'h05) + 3'h3;
		end
		return `TDMMX_NO_GROUP;
	endfunction

endpackage

// >>> logic/tdmmx_mem_if.sv
/*
 carrier between the multiplexer core and its voice slot memory.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface tdmmx_mem_if;
	logic we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic [4:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport ram (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> logic/tdmmx_slot_ram.sv
/*
 voice slot memory: one encoded byte per frame slot, registered read data.
 assumes write and read come from the same clock domain.
*/
`timescale 1ns/1ps
`include "tdmmx_defs.svh"

module tdmmx_slot_ram (
	// clock
	input wire logic aclk,
	// access
	tdmmx_mem_if.ram mem
);
	import tdmmx_pkg::*;

	logic [7:0] store [`TDMMX_SLOTS];
	logic [7:0] rdata_reg;

	always_ff @(posedge aclk) begin
		if (mem.we) begin
			store[mem.waddr] <= mem.wdata;
		end
		rdata_reg <= store[mem.raddr];
	end

	assign mem.rdata = rdata_reg;
endmodule

// >>> logic/tdmmx_core.sv
/*
 2048 kbit/s primary frame slot multiplexer with 64 kbit/s and 320 kbit/s access,
 registers on AXI4-Lite.
 assumes the trunk inputs change on the selected transmit bit timing and that
 frame alignment is found elsewhere and marked by the frame sync pins.
*/
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
// Overview of operation
// - voice samples are companded into eight-bit codes with 256 values
// - even code bits inverted in voice slots only, access slots untouched
// - transmit bits paced at 2048 kbit/s from a fine phase accumulator in internal timing
// - transmit timing from received clock, external 2048 kHz, or internal
// - a timing output follows the transmit bit timing
// - sound timing signal marks each outgoing insertion frame start
// - frame bit 1 in slot 0 passes untouched for the check-bit procedure
// - voice channels 1 to 30 map to slots 1-15 and 17-31
// - four 64 kbit/s ports, each mapped to any usable slot
// - access slots reset to priority order 6, 22, 14, 30
// - sound channels are inserted and extracted by separate logic
// - sound channels A-F occupy fixed five-slot groups
// - slot 16 never carries voice encoded here
`timescale 1ns/1ps
`include "tdmmx_defs.svh"

module tdmmx_core (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timing pins
	input wire logic ext_ref_clk_pin,
	input wire logic rcv_line_clk_pin,
	output logic timing_out,
	output logic sound_timing_out,
	// trunk pins
	input wire logic insertion_trunk_input,
	input wire logic insertion_frame_sync,
	output logic insertion_trunk_output,
	input wire logic extraction_trunk_input,
	input wire logic extraction_frame_sync,
	output logic extraction_trunk_output,
	// tributary pins
	input wire tdmmx_pkg::tdmmx_acc_t insertion_64k_port,
	output tdmmx_pkg::tdmmx_acc_t extraction_64k_port,
	output tdmmx_pkg::tdmmx_acc_t access_slot_active,
	input wire tdmmx_pkg::tdmmx_snd_t insertion_sound_port,
	output tdmmx_pkg::tdmmx_snd_t extraction_sound_port,
	output tdmmx_pkg::tdmmx_snd_t sound_slot_active
);
	import tdmmx_pkg::*;

	localparam logic [31:0] NCO_INC =
		32'((64'(`TDMMX_BIT_HZ) << 32) / 64'(`TDMMX_CLK_HZ));

	tdmmx_state_t s_reg;
	tdmmx_state_t s_next;
	tdmmx_mem_if mem ();

	//////////////////////////////////////////////////////////////////////////
	// voice slot memory
	tdmmx_slot_ram u_ram (
		.aclk(aclk),
		.mem(mem)
	);
	assign mem.we = s_reg.mem_we;
	assign mem.waddr = s_reg.mem_waddr;
	assign mem.wdata = s_reg.mem_wdata;
	assign mem.raddr = s_reg.ipos[7:3];

	//////////////////////////////////////////////////////////////////////////
	// slot decode per access port
	logic [7:0] icur;
	logic [7:0] ecur;
	logic [4:0] icur_slot;
	logic [4:0] ecur_slot;
	tdmmx_acc_t ins_hit;
	tdmmx_acc_t ext_hit;
	// frame sync forces bit 0 of slot 0
	assign icur = s_reg.ifs_s[1] ? 8'h00 : s_reg.ipos;
	assign ecur = s_reg.efs_s[1] ? 8'h00 : s_reg.epos;
	assign icur_slot = icur[7:3];
	assign ecur_slot = ecur[7:3];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_port
			logic [4:0] ps;
			logic ok;
			assign ps = s_reg.map[8 * gi +: 5];
			assign ok = s_reg.map[8 * gi + 7] && ps != `TDMMX_SLOT_ALIGN
				&& ps != `TDMMX_SLOT_SIG;
			assign ins_hit[gi] = ok && ps == icur_slot;
			assign ext_hit[gi] = ok && ps == ecur_slot;
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [32:0] acc;
		logic [7:0] vbyte;
		logic [2:0] ig;
		logic [2:0] eg;
		logic [4:0] ch;
		logic [31:0] rd;
		tdmmx_src_t src;
		logic bit_v;
		s_next = s_reg;
		acc = {1'b0, s_reg.nco} + {1'b0, NCO_INC};
		vbyte = mem.rdata ^ `TDMMX_VOICE_INV;
		ig = tdmmx_group(icur_slot);
		eg = tdmmx_group(ecur_slot);
		ch = s_reg.wdata[`TDMMX_VOICE_CH];
		rd = 32'h0000_0000;
		src = SRC_PASS;
		bit_v = 1'b0;

		// pin synchronisers
		s_next.ref_s = {s_reg.ref_s[1:0], ext_ref_clk_pin};
		s_next.rcv_s = {s_reg.rcv_s[1:0], rcv_line_clk_pin};
		s_next.ifs_s = {s_reg.ifs_s[0], insertion_frame_sync};
		s_next.efs_s = {s_reg.efs_s[0], extraction_frame_sync};
		s_next.ins_s = {s_reg.ins_s[0], insertion_trunk_input};
		s_next.ext_s = {s_reg.ext_s[0], extraction_trunk_input};
		s_next.a64_s1 = insertion_64k_port;
		s_next.a64_s2 = s_reg.a64_s1;
		s_next.snd_s1 = insertion_sound_port;
		s_next.snd_s2 = s_reg.snd_s1;

		// transmit bit timing
		s_next.nco = acc[31:0];
		unique case (s_reg.ctrl[`TDMMX_CTRL_TSRC])
			TSRC_EXTERNAL: s_next.strobe = s_reg.ref_s[1] & ~s_reg.ref_s[2];
			TSRC_RECEIVED: s_next.strobe = s_reg.rcv_s[1] & ~s_reg.rcv_s[2];
			default: s_next.strobe = acc[32];
		endcase
		s_next.gap = s_reg.strobe ? 8'h01 : (s_reg.gap == 8'hFF ? 8'hFF : s_reg.gap + 8'h01);

		// bit processing on each strobe
		if (s_reg.strobe) begin
			s_next.timing_out = ~s_reg.timing_out;
			s_next.sound_timing = icur_slot == `TDMMX_SLOT_ALIGN;
			s_next.ipos = icur + 8'h01;
			s_next.epos = ecur + 8'h01;
			if (icur == 8'hFF) begin
				s_next.frames = s_reg.frames + 16'h0001;
			end
			if (icur_slot == `TDMMX_SLOT_ALIGN || icur_slot == `TDMMX_SLOT_SIG) begin
				src = SRC_PASS;
			end else if (ig != `TDMMX_NO_GROUP && s_reg.ctrl[8 + ig]) begin
				src = SRC_SOUND;
			end else if (|ins_hit) begin
				src = SRC_ACCESS;
			end else if (s_reg.ctrl[`TDMMX_CTRL_VOICE]) begin
				src = SRC_VOICE;
			end
			unique case (src)
				SRC_SOUND: bit_v = s_reg.snd_s2[ig];
				SRC_ACCESS: bit_v = (s_reg.a64_s2 & ins_hit) != 4'h0;
				SRC_VOICE: bit_v = vbyte[3'h7 - icur[2:0]];
				SRC_PASS: bit_v = s_reg.ins_s[1];
			endcase
			s_next.ins_out = bit_v;
			s_next.ext_out = s_reg.ext_s[1];
			s_next.acc_act = ext_hit;
			s_next.snd_act = 6'h00;
			for (int k = 0; k < 4; k++) begin
				if (ext_hit[k]) begin
					s_next.e64_out[k] = s_reg.ext_s[1];
				end
			end
			if (eg != `TDMMX_NO_GROUP && s_reg.ctrl[8 + eg]) begin
				s_next.esnd_out[eg] = s_reg.ext_s[1];
				s_next.snd_act[eg] = 1'b1;
			end
		end

		// bus write channel
		s_next.mem_we = 1'b0;
		if (s_reg.awready && s_axi_awvalid) begin
			s_next.aw_have = 1'b1;
			s_next.awready = 1'b0;
			s_next.aw_word = s_axi_awaddr[7:2];
		end
		if (s_reg.wready && s_axi_wvalid) begin
			s_next.w_have = 1'b1;
			s_next.wready = 1'b0;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `TDMMX_RESP_OKAY;
			for (int b = 0; b < 4; b++) begin
				if (s_reg.wstrb[b] && s_reg.aw_word == `TDMMX_OFS_CTRL) begin
					s_next.ctrl[8 * b +: 8] = s_reg.wdata[8 * b +: 8];
				end
				if (s_reg.wstrb[b] && s_reg.aw_word == `TDMMX_OFS_MAP) begin
					s_next.map[8 * b +: 8] = s_reg.wdata[8 * b +: 8];
				end
			end
			if (s_reg.aw_word == `TDMMX_OFS_VOICE) begin
				if (&s_reg.wstrb[2:0] && ch != 5'h00 && ch <= `TDMMX_NUM_VOICE) begin
					s_next.mem_we = 1'b1;
					s_next.mem_waddr = ch <= 5'h0F ? ch : ch + 5'h01;
					s_next.mem_wdata = tdmmx_alaw(s_reg.wdata[`TDMMX_VOICE_NEG],
						s_reg.wdata[`TDMMX_VOICE_MAG]);
				end
			end else if (s_reg.aw_word != `TDMMX_OFS_CTRL && s_reg.aw_word != `TDMMX_OFS_MAP) begin
				s_next.bresp = `TDMMX_RESP_DECERR;
			end
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end

		// bus read channel
		if (s_reg.arready && s_axi_arvalid) begin
			s_next.arready = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = `TDMMX_RESP_OKAY;
			unique case (s_axi_araddr[7:2])
				`TDMMX_OFS_CTRL: rd = s_reg.ctrl & 32'h0000_3F07;
				`TDMMX_OFS_MAP: rd = s_reg.map & 32'h9F9F_9F9F;
				`TDMMX_OFS_VOICE: rd = 32'h0000_0000;
				`TDMMX_OFS_STATUS: rd = {11'h000, s_reg.ipos[7:3], s_reg.frames};
				default: s_next.rresp = `TDMMX_RESP_DECERR;
			endcase
			s_next.rdata = rd;
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
			s_next.arready = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.map <= `TDMMX_MAP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rdata = s_reg.rdata;
	assign timing_out = s_reg.timing_out;
	assign sound_timing_out = s_reg.sound_timing;
	assign insertion_trunk_output = s_reg.ins_out;
	assign extraction_trunk_output = s_reg.ext_out;
	assign extraction_64k_port = s_reg.e64_out;
	assign access_slot_active = s_reg.acc_act;
	assign extraction_sound_port = s_reg.esnd_out;
	assign sound_slot_active = s_reg.snd_act;

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	slot_zero_pass_a: assert property (s_reg.strobe && icur_slot == 5'h00
		|=> insertion_trunk_output == $past(s_reg.ins_s[1])) else $error("slot 0 altered");
	slot_sig_pass_a: assert property (s_reg.strobe && icur_slot == 5'h10
		|=> insertion_trunk_output == $past(s_reg.ins_s[1])) else $error("slot 16 altered");
	voice_invert_a: assert property (s_reg.strobe && icur_slot == 5'h03
		&& !s_reg.ctrl[8] && ins_hit == 4'h0 && s_reg.ctrl[2]
		|=> insertion_trunk_output == $past(mem.rdata[3'h7 - s_reg.ipos[2:0]]
		^ s_reg.ipos[0])) else $error("voice bit not inverted right");
	access_plain_a: assert property (s_reg.strobe && ins_hit[0] && icur_slot != 5'h00
		&& (tdmmx_group(icur_slot) == 3'h7 || !s_reg.ctrl[8 + tdmmx_group(icur_slot)])
		|=> insertion_trunk_output == $past(s_reg.a64_s2[0])) else $error("access bit wrong");
	sound_group_a: assert property (s_reg.strobe && icur_slot >= 5'h16
		&& icur_slot <= 5'h1A && s_reg.ctrl[12]
		|=> insertion_trunk_output == $past(s_reg.snd_s2[4])) else $error("group E wrong");
	bit_pace_a: assert property (s_reg.strobe && s_reg.ctrl[1:0] == 2'h0
		&& $past(s_reg.ctrl[1:0], 100) == 2'h0 && s_reg.gap != 8'h00
		|-> s_reg.gap >= 8'h61 && s_reg.gap <= 8'h62) else $error("bit spacing off");
	ext_timing_a: assert property (s_reg.ctrl[1:0] == 2'h1
		&& $past(s_reg.ctrl[1:0]) == 2'h1 && $rose(s_reg.ref_s[2])
		|-> s_reg.strobe) else $error("external edge missed");
	timing_follow_a: assert property (s_reg.strobe
		|=> timing_out != $past(timing_out)) else $error("timing output stuck");
	frame_mark_a: assert property (s_reg.strobe && icur == 8'h00
		|=> sound_timing_out ##1 sound_timing_out[*7]) else $error("frame mark lost");
	voice_slot_a: assert property (s_reg.mem_we
		|-> s_reg.mem_waddr != 5'h00 && s_reg.mem_waddr != 5'h10) else $error("bad voice slot");
	alaw_code_a: assert property (s_reg.mem_we && $past(s_reg.wdata[11:0]) == 12'h000
		|-> s_reg.mem_wdata[6:0] == 7'h00) else $error("zero sample misencoded");
	access_reset_a: assert property ($rose(aresetn)
		|-> s_reg.map[4:0] == 5'h06 && s_reg.map[12:8] == 5'h16) else $error("map reset wrong");

	voice_wr_c: cover property (s_reg.mem_we);
	sound_ins_c: cover property (s_reg.strobe && s_reg.ctrl[8] && icur_slot == 5'h01);
	access_ext_c: cover property (|access_slot_active);
	ext_time_c: cover property (s_reg.strobe && s_reg.ctrl[1:0] == 2'h1);
endmodule

// >>> verification/tdmmx_trunk_far.sv
/*
 far trunk model: 2048 kHz bit timing, frame sync and both trunk bit streams.
 assumes the bench samples trunk bits on the rising edge of ref_clk.
*/
`timescale 1ns/1ps

module tdmmx_trunk_far (
	// timing
	output logic ref_clk,
	// trunk bits
	output logic fsync,
	output logic ins_bit,
	output logic ext_bit
);
	int pos = 255;
	int frm = 0;
	logic [7:0] ib;
	logic [7:0] eb;

	////////////////////////////////////////////////////////////////////////////////
	// bits change on the falling edge, so they stand still around the rising edge
	initial begin
		ref_clk = 1'b0;
		fsync = 1'b0;
		ins_bit = 1'b0;
		ext_bit = 1'b0;
		forever begin
			#244.141 ref_clk = 1'b1;
			#244.141 ref_clk = 1'b0;
			pos = (pos + 1) % 256;
			frm = pos == 0 ? frm + 1 : frm;
			ib = 8'(pos / 8 * 29 + frm) ^ 8'hA5;
			eb = 8'(pos / 8 * 11 + frm) ^ 8'h5A;
			ins_bit = ib[7 - pos % 8];
			ext_bit = eb[7 - pos % 8];
			fsync = pos == 0;
		end
	end
endmodule

// >>> verification/test_tdm_slot_mux_2048k.sv
/*
 bench of the slot multiplexer: registers over AXI4-Lite, then a bit-by-bit frame compare.
 assumes the far trunk model paces both trunk inputs and both timing pins.
*/
`timescale 1ns/1ps

module test_tdm_slot_mux_2048k;
	import tdmmx_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, aligned;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, map_v, ctrl_v;
	logic [1:0] bresp, rresp;
	logic ref_clk, fsync, ins_bit, ext_bit, t_out, st_out, ins_out, ext_out;
	tdmmx_acc_t acc_in = 4'h0;
	tdmmx_acc_t acc_out, acc_act;
	tdmmx_snd_t snd_in = 6'h00;
	tdmmx_snd_t snd_out, snd_act;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	int pos = 0;
	logic [7:0] vexp [32];

	tdmmx_core i_tdmmx_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_ref_clk_pin(ref_clk),
		.rcv_line_clk_pin(ref_clk), .timing_out(t_out), .sound_timing_out(st_out),
		.insertion_trunk_input(ins_bit), .insertion_frame_sync(fsync),
		.insertion_trunk_output(ins_out), .extraction_trunk_input(ext_bit),
		.extraction_frame_sync(fsync), .extraction_trunk_output(ext_out),
		.insertion_64k_port(acc_in), .extraction_64k_port(acc_out),
		.access_slot_active(acc_act), .insertion_sound_port(snd_in),
		.extraction_sound_port(snd_out), .sound_slot_active(snd_act));

	tdmmx_trunk_far i_tdmmx_trunk_far (.ref_clk(ref_clk), .fsync(fsync), .ins_bit(ins_bit),
		.ext_bit(ext_bit));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches++;
			report_and_stop;
		end
	end

	// tributary inputs change off the sampling point of each bit
	always @(negedge ref_clk) begin
		@(posedge aclk);
		acc_in <= 4'($urandom);
		snd_in <= 6'($urandom);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t slot bit %0d: got %h expected %h", $time, pos, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			done = bvalid;
			r = bresp;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			done = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 1'b0;
	endtask

	function automatic logic [7:0] enc(input logic n, input logic [11:0] m);
		logic [2:0] sg;
		logic [3:0] mt;
		sg = 3'h0;
		mt = m[4:1];
		for (int k = 7; k >= 1; k--) begin
			if (m[k + 4] && sg == 3'h0) begin
				sg = 3'(k);
				mt = m[k + 3 -: 4];
			end
		end
		return {~n, sg, mt} ^ 8'h55;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// model of one trunk bit per pass, sampled well after the output strobe
	task automatic run_bits(input int n);
		logic ib, eb, e, pt, hit;
		tdmmx_acc_t a;
		tdmmx_snd_t s;
		int sl, b, g, cnt;
		cnt = 0;
		pt = t_out;
		while (cnt < n) begin
			@(posedge ref_clk);
			pos = fsync ? 0 : (pos + 1) % 256;
			aligned = aligned | fsync;
			ib = ins_bit;
			eb = ext_bit;
			a = acc_in;
			s = snd_in;
			repeat (40) @(posedge aclk);
			if (aligned) begin
				sl = pos / 8;
				b = pos % 8;
				g = sl % 16 == 0 ? 7 : (sl < 16 ? (sl - 1) / 5 : (sl - 17) / 5 + 3);
				e = ib;
				hit = 1'b0;
				if (g < 6 && ctrl_v[8 + g]) begin
					e = s[g];
					hit = 1'b1;
				end
				for (int k = 0; k < 4; k++) begin
					if (!hit && sl % 16 != 0 && map_v[8 * k + 7] && map_v[8 * k +: 5] == sl) begin
						e = a[k];
						hit = 1'b1;
					end
				end
				if (!hit && sl % 16 != 0 && ctrl_v[2]) e = vexp[sl][7 - b];
				chk_bit({5'h0, ins_out}, {5'h0, e});
				chk_bit({5'h0, ext_out}, {5'h0, eb});
				chk_bit({5'h0, st_out}, {5'h0, sl == 0});
				chk_bit({5'h0, t_out}, {5'h0, ~pt});
				chk_bit(snd_act, g < 6 ? 6'(ctrl_v[8 + g]) << g : 6'h00);
				if (g < 6 && ctrl_v[8 + g]) chk_bit({5'h0, snd_out[g]}, {5'h0, eb});
				for (int k = 0; k < 4; k++) begin
					hit = map_v[8 * k + 7] && map_v[8 * k +: 5] == sl;
					chk_bit({5'h0, acc_act[k]}, {5'h0, hit});
					if (hit) chk_bit({5'h0, acc_out[k]}, {5'h0, eb});
				end
				cnt++;
			end
			pt = t_out;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic n;
		logic [11:0] m;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, aligned} = 7'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		void'($urandom(32'h35C4));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h00, d, r);
		chk_reg(d, 32'h0);
		axi_rd(8'h04, d, r);
		chk_reg(d, 32'h1E0E1606);
		axi_rd(8'h10, d, r);
		chk_reg({30'h0, r}, 32'h3);
		axi_wr(8'h14, 32'h0, r);
		chk_reg({30'h0, r}, 32'h3);
		$display("register reset values done");
		for (int c = 1; c <= 30; c++) begin
			n = 1'($urandom);
			m = c == 5 ? 12'h000 : 12'($urandom);
			vexp[c < 16 ? c : c + 1] = enc(n, m);
			axi_wr(8'h08, {11'h0, 5'(c), 3'h0, n, m}, r);
		end
		axi_rd(8'h08, d, r);
		chk_reg(d, 32'h0);
		map_v = 32'h1E0E9686;
		axi_wr(8'h04, map_v, r);
		chk_reg({30'h0, r}, 32'h0);
		axi_rd(8'h04, d, r);
		chk_reg(d, map_v);
		ctrl_v = 32'h3005;
		axi_wr(8'h00, ctrl_v, r);
		run_bits(256);
		$display("full frame on external timing done");
		ctrl_v = 32'h3006;
		axi_wr(8'h00, ctrl_v, r);
		run_bits(64);
		$display("received timing done");
		for (int t = 0; t < 4; t += 3) begin
			ctrl_v = 32'(t);
			axi_wr(8'h00, ctrl_v, r);
			d = 32'h0;
			n = t_out;
			repeat (1024) begin
				@(posedge aclk);
				if (t_out !== n) d++;
				n = t_out;
			end
			chk_reg(32'(d == 10 || d == 11), 32'h1);
		end
		$display("internal timing done");
		report_and_stop;
	end
endmodule
